/* rtl/dbgrap_pkg.sv */
// Constants, types and helpers shared by both ends of the debug register access port.
// Assumes one clock (clk_sys, 50 MHz) and a synchronous active-low reset on both ends.

package dbgrap_pkg;

  // ==========================================================================
  // Register numbers (byte offset is number times four)
  localparam logic [6:0] REG_ID = 7'h00;
  localparam logic [6:0] REG_STATUS = 7'h01;
  localparam logic [6:0] REG_RUN_REQ = 7'h04;
  localparam logic [6:0] REG_DTR = 7'h05;
  localparam logic [6:0] REG_BVR_BASE = 7'h40;
  localparam logic [6:0] REG_BCR_BASE = 7'h50;
  localparam logic [6:0] REG_WVR_BASE = 7'h60;
  localparam logic [6:0] REG_WCR_BASE = 7'h70;
  localparam int REG_GROUP_SIZE = 16;
  localparam int REG_COUNT = 128;

  // ==========================================================================
  // Map geometry
  localparam int MAP_BYTES = 4096;
  localparam int MAP_IDX_BITS = 10;
  localparam int EXT_ADDR_BIT = 31;

  // ==========================================================================
  // Status/control fields and masks
  localparam int DEBUG_STATUS_CTRL_REG_UCOMM_DIS_BIT = 12;
  localparam int DEBUG_STATUS_CTRL_REG_MODE_LO = 14;
  localparam int DEBUG_STATUS_CTRL_REG_MODE_HI = 15;
  localparam logic [1:0] MODE_MONITOR = 2'h2;
  localparam logic [31:0] DEBUG_STATUS_CTRL_REG_RST = 32'h0000_0000;
  localparam logic [31:0] DEBUG_STATUS_CTRL_REG_CP_WR_MASK = 32'h0000_D000;
  localparam logic [31:0] DEBUG_STATUS_CTRL_REG_EXT_WR_MASK = 32'h0000_F000;
  localparam logic [31:0] DEBUG_STATUS_CTRL_REG_SW_WR_MASK = 32'h0000_3000;
  localparam logic [31:0] REG_RST = 32'h0000_0000;

  typedef enum logic [1:0] {ACC_RSVD, ACC_RO, ACC_WO, ACC_RW} dbgrap_acc_t;

  // Access type of a register number, given implemented breakpoint/watchpoint counts
  function automatic dbgrap_acc_t dbgrap_acc_type(input logic [6:0] num, input int nbrp,
                                                  input int nwrp);
    int slot;
    slot = int'(num[3:0]);
    if (num == REG_ID) begin
      return ACC_RO;
    end
    if (num == REG_STATUS || num == REG_DTR) begin
      return ACC_RW;
    end
    if (num == REG_RUN_REQ) begin
      return ACC_WO;
    end
    if (num[6:4] == REG_BVR_BASE[6:4] || num[6:4] == REG_BCR_BASE[6:4]) begin
      return (slot < nbrp) ? ACC_RW : ACC_RSVD;
    end
    if (num[6:4] == REG_WVR_BASE[6:4] || num[6:4] == REG_WCR_BASE[6:4]) begin
      return (slot < nwrp) ? ACC_RW : ACC_RSVD;
    end
    return ACC_RSVD;
  endfunction : dbgrap_acc_type

  function automatic logic [31:0] dbgrap_swap(input logic [31:0] w);
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction : dbgrap_swap

endpackage : dbgrap_pkg

/* rtl/dbgrap_if.sv */
// Debug port joining the system bridge to the device's register file.
// Assumes both ends run on clk_sys; read data stands in the cycle after the read strobe.

`timescale 1ns/1ps

interface dbgrap_if;
  logic dp_wr;
  logic dp_rd;
  logic [31:2] debug_port_address;
  logic [31:0] dp_wdata;
  logic [31:0] dp_rdata;

  modport device_end (
    input dp_wr,
    input dp_rd,
    input debug_port_address,
    input dp_wdata,
    output dp_rdata
  );

  modport bridge_end (
    output dp_wr,
    output dp_rd,
    output debug_port_address,
    output dp_wdata,
    input dp_rdata
  );
endinterface : dbgrap_if

/* rtl/dbgrap_device.sv */
// Debug register file with coprocessor access gating and a word-only debug port.
// Assumes the core presents one coprocessor instruction per cp_valid pulse and takes
// cp_undef as its undefined-instruction exception request.

`timescale 1ns/1ps

module dbgrap_device
  import dbgrap_pkg::*;
#(
  parameter int NUM_BRP = 6,
  parameter int NUM_WRP = 8,
  // Identification value is arbitrary
  parameter logic [31:0] ID_VALUE = 32'h0000_1234,
  parameter bit MEM_MAP_EN = 1'b1,
  parameter bit EXT_CP_EN = 1'b1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Core state
  input wire logic debug_state,
  input wire logic user_mode,
  // Coprocessor instruction request
  input wire logic cp_valid,
  input wire logic cp_write,
  input wire logic [3:0] cp_crn,
  input wire logic [3:0] cp_crm,
  input wire logic [2:0] cp_op2,
  input wire logic [31:0] cp_wdata,
  // Coprocessor answer
  output logic cp_done,
  output logic cp_undef,
  output logic [31:0] cp_rdata,
  // Status view for the core
  output logic [31:0] status_ctrl,
  // Debug port
  dbgrap_if.device_end port
);

  // ==========================================================================
  // Parameter checks
  if (NUM_BRP < 1 || NUM_BRP > REG_GROUP_SIZE || NUM_WRP < 1 || NUM_WRP > REG_GROUP_SIZE)
  begin : g_bad_count
    $error("breakpoint and watchpoint counts must lie in 1..16");
  end
  if (!MEM_MAP_EN && !EXT_CP_EN) begin : g_bad_iface
    $error("without the memory map the extended coprocessor path is required");
  end

  // ==========================================================================
  // State
  logic [31:0] debug_status_ctrl_reg_ff;
  logic [31:0] regs_ff [REG_COUNT];
  logic cp_done_ff;
  logic cp_undef_ff;
  logic [31:0] cp_rdata_ff;
  logic [31:0] dp_rdata_ff;

  // ==========================================================================
  // Coprocessor decode
  logic [6:0] cp_num;
  dbgrap_acc_t cp_acc;
  logic cp_base;
  logic cp_int_wr;
  logic cp_perm;
  logic cp_type_ok;
  logic cp_ok;
  logic cp_wr_en;

  function automatic logic [31:0] read_value(input logic [6:0] num);
    if (num == REG_ID) begin
      return ID_VALUE;
    end
    if (num == REG_STATUS) begin
      return debug_status_ctrl_reg_ff;
    end
    return regs_ff[num];
  endfunction : read_value

  // ==========================================================================
  // Access-type helpers, shared by the coprocessor path and the debug port
  function automatic logic acc_writable(input dbgrap_acc_t acc);
    return acc == ACC_WO || acc == ACC_RW;
  endfunction : acc_writable

  function automatic logic acc_readable(input dbgrap_acc_t acc);
    return acc == ACC_RO || acc == ACC_RW;
  endfunction : acc_readable

  always_comb begin
    cp_num = {cp_op2, cp_crm};
    cp_acc = dbgrap_acc_type(cp_num, NUM_BRP, NUM_WRP);
    cp_base = (!cp_write && (cp_num == REG_ID || cp_num == REG_STATUS))
              || cp_num == REG_DTR;
    cp_int_wr = cp_write && cp_num == REG_STATUS;
    if (cp_crn != 4'h0) begin
      cp_perm = 1'b0;
    end else if (debug_state) begin
      cp_perm = 1'b1;
    end else if (user_mode) begin
      // Comms disable blocks even baseline; status writes never pass
      cp_perm = cp_base && !debug_status_ctrl_reg_ff[DEBUG_STATUS_CTRL_REG_UCOMM_DIS_BIT];
    end else begin
      // Halting or none selected: only baseline and status write pass
      cp_perm = cp_base || cp_int_wr
                || debug_status_ctrl_reg_ff[DEBUG_STATUS_CTRL_REG_MODE_HI:DEBUG_STATUS_CTRL_REG_MODE_LO] == MODE_MONITOR;
    end
    if (!EXT_CP_EN && !cp_base && !cp_int_wr) begin
      cp_perm = 1'b0;
    end
    cp_type_ok = cp_write ? acc_writable(cp_acc) : acc_readable(cp_acc);
    cp_ok = cp_perm && cp_type_ok;
    cp_wr_en = cp_valid && cp_write && cp_ok;
  end

  // ==========================================================================
  // Debug port decode
  logic [MAP_IDX_BITS-1:0] dp_idx;
  logic dp_ext;
  logic dp_in_file;
  dbgrap_acc_t dp_acc;
  logic dp_wr_en;
  logic [31:0] dp_mask;

  always_comb begin
    // Bits 30:12 lie outside the 4KB window and bits 1:0 do not exist
    dp_idx = port.debug_port_address[MAP_IDX_BITS+1:2];
    dp_ext = port.debug_port_address[EXT_ADDR_BIT];
    dp_in_file = dp_idx < MAP_IDX_BITS'(REG_COUNT);
    // Indices past the file are reserved: writes dropped, reads zero
    dp_acc = dp_in_file ? dbgrap_acc_type(dp_idx[6:0], NUM_BRP, NUM_WRP) : ACC_RSVD;
    dp_wr_en = MEM_MAP_EN && port.dp_wr && acc_writable(dp_acc);
    // Software port writes may not move the debug-mode select; debugger and coprocessor writes can
    dp_mask = dp_ext ? DEBUG_STATUS_CTRL_REG_EXT_WR_MASK : DEBUG_STATUS_CTRL_REG_SW_WR_MASK;
  end

  // ==========================================================================
  // Status/control register
  // A port write in the same cycle as a coprocessor write wins: the debugger is master.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      debug_status_ctrl_reg_ff <= DEBUG_STATUS_CTRL_REG_RST;
    end else if (dp_wr_en && dp_idx[6:0] == REG_STATUS) begin
      debug_status_ctrl_reg_ff <= (debug_status_ctrl_reg_ff & ~dp_mask) | (port.dp_wdata & dp_mask);
    end else if (cp_wr_en && cp_num == REG_STATUS) begin
      debug_status_ctrl_reg_ff <= (debug_status_ctrl_reg_ff & ~DEBUG_STATUS_CTRL_REG_CP_WR_MASK) | (cp_wdata & DEBUG_STATUS_CTRL_REG_CP_WR_MASK);
    end
  end

  // ==========================================================================
  // Transfer, run request, breakpoint and watchpoint registers
  // A coprocessor write colliding with a port write is dropped, not flagged undefined
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_ff[i] <= REG_RST;
      end
    end else if (dp_wr_en && dp_idx[6:0] != REG_STATUS) begin
      regs_ff[dp_idx[6:0]] <= port.dp_wdata;
    end else if (cp_wr_en && cp_num != REG_STATUS) begin
      regs_ff[cp_num] <= cp_wdata;
    end
  end

  // ==========================================================================
  // Coprocessor answer, one cycle after the request
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cp_done_ff <= 1'b0;
      cp_undef_ff <= 1'b0;
    end else begin
      cp_done_ff <= cp_valid;
      cp_undef_ff <= cp_valid && !cp_ok;
    end
  end

  // Read data is zero unless the read was permitted, so a refused read leaks nothing
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cp_rdata_ff <= 32'h0000_0000;
    end else if (cp_valid && !cp_write && cp_ok) begin
      cp_rdata_ff <= read_value(cp_num);
    end else begin
      cp_rdata_ff <= 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Debug port read data: word only, lanes straight, zero for reserved and write-only
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      dp_rdata_ff <= 32'h0000_0000;
    end else if (MEM_MAP_EN && port.dp_rd && acc_readable(dp_acc)) begin
      dp_rdata_ff <= read_value(dp_idx[6:0]);
    end else begin
      dp_rdata_ff <= 32'h0000_0000;
    end
  end

  assign cp_done = cp_done_ff;
  assign cp_undef = cp_undef_ff;
  assign cp_rdata = cp_rdata_ff;
  assign status_ctrl = debug_status_ctrl_reg_ff;
  assign port.dp_rdata = dp_rdata_ff;

endmodule : dbgrap_device

/* rtl/dbgrap_bridge.sv */
// System bridge end: turns plain word reads and writes into debug port accesses.
// Assumes the master's read data is wanted one cycle after its read strobe.

`timescale 1ns/1ps

module dbgrap_bridge
  import dbgrap_pkg::*;
#(
  parameter logic [31:0] BASE_ADDR = 32'h0000_0000
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Master side
  input wire logic [31:0] sys_addr,
  input wire logic [31:0] sys_wdata,
  input wire logic sys_wr,
  input wire logic sys_rd,
  output logic [31:0] sys_rdata,
  // Master attributes
  input wire logic sys_big_endian,
  input wire logic sys_ext_dbg,
  // Debug port
  dbgrap_if.bridge_end port
);

  // ==========================================================================
  // Parameter check
  if (BASE_ADDR % MAP_BYTES != 0) begin : g_bad_base
    $error("base address must sit on a 4KB boundary");
  end

  logic hit;
  logic rd_hit_ff;
  logic rd_swap_ff;

  // Only word accesses exist on this side, so no byte enables are forwarded
  assign hit = sys_addr[31:12] == BASE_ADDR[31:12];
  assign port.dp_wr = sys_wr && hit;
  assign port.dp_rd = sys_rd && hit;
  assign port.debug_port_address = {sys_ext_dbg, 19'h0_0000, sys_addr[11:2]};
  assign port.dp_wdata = sys_big_endian ? dbgrap_swap(sys_wdata) : sys_wdata;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rd_hit_ff <= 1'b0;
      rd_swap_ff <= 1'b0;
    end else begin
      rd_hit_ff <= sys_rd && hit;
      rd_swap_ff <= sys_big_endian;
    end
  end

  // Misses read as zero so a stray read never returns stale data
  assign sys_rdata = !rd_hit_ff ? 32'h0000_0000
                   : rd_swap_ff ? dbgrap_swap(port.dp_rdata) : port.dp_rdata;

endmodule : dbgrap_bridge

/* sim/dbgrap_checker.sv */
// Concurrent checks on the debug port between bridge and device.
// Assumes it sits beside the interface, on clk_sys with active-low reset.
`timescale 1ns/1ps
module dbgrap_checker #(
  parameter logic [31:0] ID_VALUE = 32'h0000_0000,
  parameter int NUM_WRP = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Debug port
  input wire logic dp_wr,
  input wire logic dp_rd,
  input wire logic [31:2] debug_port_address,
  input wire logic [31:0] dp_wdata,
  input wire logic [31:0] dp_rdata
);
  // ==========================================
  // Decode
  logic [9:0] rn;
  assign rn = debug_port_address[11:2];
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  sequence s_rd(int n);
    dp_rd && rn == n;
  endsequence
  sequence s_wr(int n);
    dp_wr && rn == n;
  endsequence
  sequence s_xwr(int n);
    dp_wr && rn == n && debug_port_address[31];
  endsequence
  // ==========================================
  // Properties
  property p_idle;
    !dp_rd |=> dp_rdata == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("read data without read");
  property p_excl;
    !(dp_rd && dp_wr);
  endproperty
  a_excl: assert property (p_excl) else $error("read and write together");
  property p_map;
    (dp_rd || dp_wr) |-> debug_port_address[30:12] == 19'h0;
  endproperty
  a_map: assert property (p_map) else $error("address outside map");
  property p_id;
    s_rd(0) |=> dp_rdata == ID_VALUE;
  endproperty
  a_id: assert property (p_id) else $error("wrong id word");
  property p_wo;
    s_rd(4) |=> dp_rdata == 32'h0;
  endproperty
  a_wo: assert property (p_wo) else $error("write-only reg read back");
  property p_wpt;
    s_rd(96 + NUM_WRP) |=> dp_rdata == 32'h0;
  endproperty
  a_wpt: assert property (p_wpt) else $error("absent watchpoint read");
  property p_stat;
    s_rd(1) |=> (dp_rdata & 32'hFFFF_0FFF) == 32'h0;
  endproperty
  a_stat: assert property (p_stat) else $error("status has stray bits");
  // Debugger write lands in all four writable status bits
  property p_ext;
    s_xwr(1) ##1 s_rd(1) |=> dp_rdata[15:12] == $past(dp_wdata[15:12], 2);
  endproperty
  a_ext: assert property (p_ext) else $error("status write lost");
  property p_dtr;
    s_wr(5) ##1 s_rd(5) |=> dp_rdata == $past(dp_wdata, 2);
  endproperty
  a_dtr: assert property (p_dtr) else $error("transfer word altered");
endmodule : dbgrap_checker

/* sim/dbgrap_bench.sv */
// Bench joining bridge and device over the debug port, against a model.
// Assumes clk_sys at 50 MHz and a synchronous active-low reset.
`timescale 1ns/1ps
module dbgrap_bench;
  // Identification value is arbitrary
  localparam logic [31:0] ID_VAL = 32'h0000_5A3C;
  // ==========================================
  // Signals and model state
  logic clk_sys = 1'b0, nrst = 1'b0, debug_state = 1'b0, user_mode = 1'b0;
  logic cp_valid = 1'b0, cp_write = 1'b0, sys_wr = 1'b0, sys_rd = 1'b0;
  logic sys_big_endian = 1'b0, sys_ext_dbg = 1'b0, cp_done, cp_undef;
  logic [3:0] cp_crn = 4'h0, cp_crm = 4'h0;
  logic [2:0] cp_op2 = 3'h0;
  logic [31:0] cp_wdata = 32'h0, sys_addr = 32'h0, sys_wdata = 32'h0;
  logic [31:0] cp_rdata, status_ctrl, sys_rdata, r;
  logic [31:0] st = 32'h0;
  logic [31:0] mreg [128];
  int n_errors = 0, comparisons = 0, cycles = 0;
  int seed = 32'hBC94BAC8;
  dbgrap_if bus ();
  dbgrap_device #(.ID_VALUE(ID_VAL)) dbgrap_device_i (.clk_sys, .nrst, .debug_state,
    .user_mode, .cp_valid, .cp_write, .cp_crn, .cp_crm, .cp_op2, .cp_wdata, .cp_done,
    .cp_undef, .cp_rdata, .status_ctrl, .port(bus));
  dbgrap_bridge #(.BASE_ADDR(32'h0)) dbgrap_bridge_i (.clk_sys, .nrst, .sys_addr,
    .sys_wdata, .sys_wr, .sys_rd, .sys_rdata, .sys_big_endian, .sys_ext_dbg, .port(bus));
  dbgrap_checker #(.ID_VALUE(ID_VAL), .NUM_WRP(8)) dbgrap_checker_i (.clk_sys, .nrst,
    .dp_wr(bus.dp_wr), .dp_rd(bus.dp_rd), .debug_port_address(bus.debug_port_address),
    .dp_wdata(bus.dp_wdata), .dp_rdata(bus.dp_rdata));
  always #10 clk_sys = ~clk_sys;
  // ==========================================
  // Model helpers: 0 reserved, 1 read-only, 2 write-only, 3 read-write
  function automatic int acc(input int n);
    if (n == 0) return 1;
    if (n == 1 || n == 5) return 3;
    if (n == 4) return 2;
    if (n >= 64 && n < 96) return (n % 16 < 6) ? 3 : 0;
    if (n >= 96 && n < 128) return (n % 16 < 8) ? 3 : 0;
    return 0;
  endfunction : acc
  function automatic logic [31:0] sw(input logic [31:0] w);
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction : sw
  function automatic logic [31:0] rdv(input int n);
    return (n == 0) ? ID_VAL : (n == 1) ? st : mreg[n];
  endfunction : rdv
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic test_done;
    if (n_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  // ==========================================
  // Coprocessor instruction, answered one cycle later
  task automatic cp_op(input logic ds, um, wr, input int n, input logic [3:0] crn,
                       input logic [31:0] wd);
    logic base, und;
    logic [31:0] exp;
    base = (!wr && n <= 1) || n == 5;
    und = crn != 4'h0;
    if (!ds && um && (st[12] || !base)) und = 1'b1;
    if (!ds && !um && !base && !(wr && n == 1) && st[15:14] != 2'h2) und = 1'b1;
    if (wr ? acc(n) < 2 : acc(n) % 2 == 0) und = 1'b1;
    if (!und && wr && n == 1) st = (st & ~32'h0000_D000) | (wd & 32'h0000_D000);
    else if (!und && wr) mreg[n] = wd;
    exp = (!und && !wr) ? rdv(n) : 32'h0;
    @(posedge clk_sys);
    {debug_state, user_mode, cp_write, cp_crn, cp_wdata} <= {ds, um, wr, crn, wd};
    {cp_op2, cp_crm} <= 7'(n);
    cp_valid <= 1'b1;
    sys_wr <= 1'b0;
    @(posedge clk_sys);
    cp_valid <= 1'b0;
    #1;
    check(32'({cp_done, cp_undef}), 32'({1'b1, und}));
    check(cp_rdata, exp);
    check(status_ctrl, st);
  endtask : cp_op
  // Port access; a write stays up until the next access so a read may follow at once
  task automatic sys_op(input logic wr, input logic [31:0] a, wd, input logic be, ext);
    int n;
    logic [31:0] w, m, exp;
    n = int'(a[11:2]);
    w = be ? sw(wd) : wd;
    m = ext ? 32'h0000_F000 : 32'h0000_3000;
    exp = 32'h0;
    if (a[31:12] == 20'h0 && n < 128) begin
      if (wr && n == 1) st = (st & ~m) | (w & m);
      else if (wr && acc(n) >= 2) mreg[n] = w;
      if (!wr && acc(n) % 2 == 1) exp = rdv(n);
    end
    @(posedge clk_sys);
    {sys_wr, sys_rd, sys_addr, sys_wdata} <= {wr, !wr, a, wd};
    {sys_big_endian, sys_ext_dbg} <= {be, ext};
    if (!wr) begin
      @(posedge clk_sys);
      sys_rd <= 1'b0;
      #1;
      check(sys_rdata, be ? sw(exp) : exp);
    end
  endtask : sys_op
  // ==========================================
  // Sequence
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_errors++;
      test_done();
    end
  end
  initial begin
    foreach (mreg[i]) mreg[i] = 32'h0;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    sys_op(1'b1, 32'h4, 32'h0000_B000, 1'b0, 1'b1);
    sys_op(1'b0, 32'h4, 32'h0, 1'b0, 1'b0);
    sys_op(1'b1, 32'h14, 32'h1234_5678, 1'b1, 1'b0);
    sys_op(1'b0, 32'h14, 32'h0, 1'b1, 1'b0);
    cp_op(1'b0, 1'b0, 1'b1, 103, 4'h0, 32'hCAFE_0001);
    cp_op(1'b0, 1'b0, 1'b0, 103, 4'h0, 32'h0);
    cp_op(1'b0, 1'b1, 1'b0, 0, 4'h0, 32'h0);
    sys_op(1'b0, 32'h0, 32'h0, 1'b0, 1'b0);
    sys_op(1'b0, 32'h10, 32'h0, 1'b0, 1'b1);
    sys_op(1'b0, 32'h1A0, 32'h0, 1'b0, 1'b0);
    foreach (mreg[i]) if (i < 8)
      sys_op(1'b0, {23'h0, 7'(i * 23 + 2), 2'(i)}, 32'h0, i[0], 1'b0);
    for (int i = 0; i < 400; i++) begin
      r = $random(seed);
      if (r[0])
        cp_op(r[1], r[2], r[3], int'(r[10:4]), (r[13:11] == 3'h0) ? r[17:14] : 4'h0,
              $random(seed));
      else
        sys_op(r[1], {12'h0, r[2] & r[3], 7'h0, r[19] ? r[13:11] : 3'h0, r[10:4],
               r[15:14]}, $random(seed), r[16], r[17]);
    end
    @(posedge clk_sys);
    sys_wr <= 1'b0;
    test_done();
  end
endmodule : dbgrap_bench
